// file: core/fail_safe_monitor_core.sv
// Fail-safe clock monitor with its AXI4-Lite register slave.
//
// Behaviour
// RULE1 - Monitoring and fail-over happen only while monitor_enable_cfg is set.
// RULE2 - The internal RC oscillator is kept running whenever monitoring is on.
// RULE3 - The sample clock is the internal RC oscillator divided by 64.
// RULE4 - The monitor latch sets on monitored clock falls, clears on sample rises.
// RULE5 - A set latch at a sample clock fall declares a clock failure.
// RULE6 - A failure sets osc_fail_flag, bit 7 of peripheral_irq_flags_2.
// RULE7 - A failure selects the internal oscillator; osc_control_reg stays.
// RULE8 - A failure resets the watchdog timer and its postscaler.
// RULE9 - Only primary and secondary clock failures are detected.
// RULE10 - Disabling the watchdog never stops the RC oscillator while enabled.
// RULE11 - Fail-safe ends only by device reset or power-managed mode entry.
// RULE12 - After reset the internal oscillator clocks until primary is ready.
// RULE13 - On primary ready, switch to it, set primary_clock_running, monitor.
// RULE14 - A never-ready primary leaves the device on internal oscillator.
// RULE15 - Software should set internal_freq_select early after reset.
// RULE16 - No repeated fail-over while fail-safe; re-arm only after leaving it.
`timescale 1ns/1ps
`default_nettype none
module fail_safe_monitor_core #(
	parameter int unsigned P_RC_DIV = fail_safe_monitor_pkg::FAIL_SAFE_MONITOR_RC_DIV
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_mon_clk,
	input wire logic i_int_rc_osc,
	input wire logic i_primary_ready,
	input wire logic i_wdt_enable,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [fail_safe_monitor_pkg::FAIL_SAFE_MONITOR_AW-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [fail_safe_monitor_pkg::FAIL_SAFE_MONITOR_DW-1:0] i_s_axi_wdata,
	input wire logic [fail_safe_monitor_pkg::FAIL_SAFE_MONITOR_DW/8-1:0] i_s_axi_wstrb,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [fail_safe_monitor_pkg::FAIL_SAFE_MONITOR_AW-1:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [fail_safe_monitor_pkg::FAIL_SAFE_MONITOR_DW-1:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_rc_osc_en,
	output logic o_clk_sel_internal,
	output logic o_wdt_reset,
	output logic o_osc_fail_flag,
	output logic o_fail_safe
);
	import fail_safe_monitor_pkg::*;

	function automatic logic fail_safe_monitor_mapped(input logic [FAIL_SAFE_MONITOR_AW-1:0] a);
		fail_safe_monitor_mapped = (a == FAIL_SAFE_MONITOR_OFS_CTRL) || (a == FAIL_SAFE_MONITOR_OFS_OSC) ||
			(a == FAIL_SAFE_MONITOR_OFS_IRQ) || (a == FAIL_SAFE_MONITOR_OFS_STAT);
	endfunction

	// Pin synchronisers. The system clock must run well above twice the
	// monitored clock, otherwise falling edges are missed by the sampler.
	logic [1:0] mon_sync_ff;
	logic mon_prev_ff;
	logic [1:0] rdy_sync_ff;

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mon_sync_ff <= 2'h0;
			mon_prev_ff <= 1'b0;
			rdy_sync_ff <= 2'h0;
		end else begin
			mon_sync_ff <= {mon_sync_ff[0], i_mon_clk};
			mon_prev_ff <= mon_sync_ff[1];
			rdy_sync_ff <= {rdy_sync_ff[0], i_primary_ready};
		end
	end

	wire mon_fall = mon_prev_ff & ~mon_sync_ff[1];
	wire primary_ready = rdy_sync_ff[1];

	// Control and status state.
	fail_safe_monitor_state_t state_ff;
	fail_safe_monitor_state_t nxt_state;
	logic en_ff;
	logic [FAIL_SAFE_MONITOR_FSEL_W-1:0] fsel_ff;
	logic osc_run_ff;
	logic latch_ff;
	logic flag_ff;
	logic sel_ff;
	logic wdt_rst_ff;
	logic rc_en_ff;

	// AXI write side.
	logic aw_got_ff;
	logic w_got_ff;
	logic [FAIL_SAFE_MONITOR_AW-1:0] wr_addr_ff;
	logic [7:0] wr_data_ff;
	logic wr_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;

	// AXI read side.
	logic rvalid_ff;
	logic [FAIL_SAFE_MONITOR_DW-1:0] rdata_ff;
	logic [1:0] rresp_ff;

	wire aw_take = i_s_axi_awvalid & o_s_axi_awready;
	wire w_take = i_s_axi_wvalid & o_s_axi_wready;
	wire do_wr = aw_got_ff & w_got_ff & ~bvalid_ff;
	wire wr_byte = do_wr & wr_strb_ff;
	wire wr_ctrl = wr_byte & (wr_addr_ff == FAIL_SAFE_MONITOR_OFS_CTRL);
	wire wr_osc = wr_byte & (wr_addr_ff == FAIL_SAFE_MONITOR_OFS_OSC);
	wire wr_irq = wr_byte & (wr_addr_ff == FAIL_SAFE_MONITOR_OFS_IRQ);
	wire pm_pulse = wr_ctrl & wr_data_ff[FAIL_SAFE_MONITOR_CTRL_PM_BIT];
	wire irq_clr = wr_irq & wr_data_ff[FAIL_SAFE_MONITOR_IRQ_FAIL_BIT];
	wire ar_take = i_s_axi_arvalid & o_s_axi_arready;

	// Detection runs only on the external clock; while the internal
	// oscillator drives the device nothing is watched, so its own
	// failure cannot be seen and a second fail-over cannot start.
	wire monitoring = en_ff & (state_ff == FAIL_SAFE_MONITOR_ST_RUN); // RULE1 RULE9 RULE16

	wire samp_clk;
	wire samp_rise;
	wire samp_fall;

	fail_safe_monitor_rc_div #(
		.P_RC_DIV(P_RC_DIV)
	) u_rc_div (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_rc_osc(i_int_rc_osc),
		.i_run(rc_en_ff),
		.o_samp_clk(samp_clk),
		.o_samp_rise(samp_rise),
		.o_samp_fall(samp_fall)
	);

	// A monitored clock fall in the same cycle as a sample rise keeps the
	// latch set, so the edge is not lost.
	wire nxt_latch = monitoring & (mon_fall | (latch_ff & ~samp_rise)); // RULE4
	wire fail_det = monitoring & samp_fall & latch_ff; // RULE5

	// Failure sets the flag even when software clears it in that cycle.
	wire nxt_flag = fail_det | (flag_ff & ~irq_clr); // RULE6

	// The watchdog may be off, yet the RC oscillator keeps running for us.
	wire nxt_rc_en = en_ff | i_wdt_enable; // RULE2 RULE10

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			FAIL_SAFE_MONITOR_ST_BOOT: begin
				if (primary_ready) begin
					nxt_state = FAIL_SAFE_MONITOR_ST_RUN; // RULE12 RULE13 RULE14
				end
			end
			FAIL_SAFE_MONITOR_ST_RUN: begin
				if (fail_det) begin
					nxt_state = FAIL_SAFE_MONITOR_ST_FAIL; // RULE7
				end
			end
			FAIL_SAFE_MONITOR_ST_FAIL: begin
				if (pm_pulse) begin
					nxt_state = FAIL_SAFE_MONITOR_ST_BOOT; // RULE11
				end
			end
			default: begin
				nxt_state = FAIL_SAFE_MONITOR_ST_BOOT;
			end
		endcase
	end

	wire nxt_osc_run = osc_run_ff |
		((state_ff == FAIL_SAFE_MONITOR_ST_BOOT) & (nxt_state == FAIL_SAFE_MONITOR_ST_RUN)); // RULE13
	wire [FAIL_SAFE_MONITOR_FSEL_W-1:0] nxt_fsel = wr_osc ?
		wr_data_ff[FAIL_SAFE_MONITOR_OSC_FSEL_LSB +: FAIL_SAFE_MONITOR_FSEL_W] : fsel_ff;

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_ff <= FAIL_SAFE_MONITOR_ST_BOOT;
			en_ff <= 1'b0;
			fsel_ff <= FAIL_SAFE_MONITOR_FSEL_RST;
			osc_run_ff <= 1'b0;
			latch_ff <= 1'b0;
			flag_ff <= 1'b0;
			sel_ff <= 1'b1;
			wdt_rst_ff <= 1'b0;
			rc_en_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			en_ff <= wr_ctrl ? wr_data_ff[FAIL_SAFE_MONITOR_CTRL_EN_BIT] : en_ff;
			fsel_ff <= nxt_fsel;
			osc_run_ff <= nxt_osc_run;
			latch_ff <= nxt_latch;
			flag_ff <= nxt_flag;
			sel_ff <= (nxt_state != FAIL_SAFE_MONITOR_ST_RUN); // RULE7 RULE12
			wdt_rst_ff <= fail_det; // RULE8
			rc_en_ff <= nxt_rc_en;
		end
	end

	// Write channel: address and data are taken in either order and the
	// response follows once both are held.
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			wr_addr_ff <= '0;
			wr_data_ff <= 8'h00;
			wr_strb_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= FAIL_SAFE_MONITOR_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_got_ff <= 1'b1;
				wr_addr_ff <= i_s_axi_awaddr;
			end else if (do_wr) begin
				aw_got_ff <= 1'b0;
			end
			if (w_take) begin
				w_got_ff <= 1'b1;
				wr_data_ff <= i_s_axi_wdata[7:0];
				wr_strb_ff <= i_s_axi_wstrb[0];
			end else if (do_wr) begin
				w_got_ff <= 1'b0;
			end
			if (do_wr) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= fail_safe_monitor_mapped(wr_addr_ff) ?
					FAIL_SAFE_MONITOR_RESP_OKAY : FAIL_SAFE_MONITOR_RESP_SLVERR;
			end else if (i_s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Read data view. Every field lives in the low byte.
	wire [FAIL_SAFE_MONITOR_DW-1:0] ctrl_word = {{(FAIL_SAFE_MONITOR_DW-1){1'b0}}, en_ff};
	wire [FAIL_SAFE_MONITOR_DW-1:0] osc_word = FAIL_SAFE_MONITOR_DW'({fsel_ff, osc_run_ff}) <<
		FAIL_SAFE_MONITOR_OSC_RUN_BIT;
	wire [FAIL_SAFE_MONITOR_DW-1:0] irq_word = FAIL_SAFE_MONITOR_DW'(flag_ff) << FAIL_SAFE_MONITOR_IRQ_FAIL_BIT;
	wire [FAIL_SAFE_MONITOR_DW-1:0] stat_word = FAIL_SAFE_MONITOR_DW'({rc_en_ff, latch_ff, sel_ff,
		(state_ff == FAIL_SAFE_MONITOR_ST_FAIL)}) << FAIL_SAFE_MONITOR_STAT_FAIL_BIT;
	wire [FAIL_SAFE_MONITOR_DW-1:0] rd_word =
		(i_s_axi_araddr == FAIL_SAFE_MONITOR_OFS_CTRL) ? ctrl_word :
		(i_s_axi_araddr == FAIL_SAFE_MONITOR_OFS_OSC) ? osc_word :
		(i_s_axi_araddr == FAIL_SAFE_MONITOR_OFS_IRQ) ? irq_word :
		(i_s_axi_araddr == FAIL_SAFE_MONITOR_OFS_STAT) ? stat_word : '0;

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= FAIL_SAFE_MONITOR_RESP_OKAY;
		end else begin
			if (ar_take) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_word;
				rresp_ff <= fail_safe_monitor_mapped(i_s_axi_araddr) ?
					FAIL_SAFE_MONITOR_RESP_OKAY : FAIL_SAFE_MONITOR_RESP_SLVERR;
			end else if (i_s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	assign o_s_axi_awready = ~aw_got_ff & ~bvalid_ff;
	assign o_s_axi_wready = ~w_got_ff & ~bvalid_ff;
	assign o_s_axi_bvalid = bvalid_ff;
	assign o_s_axi_bresp = bresp_ff;
	assign o_s_axi_arready = ~rvalid_ff;
	assign o_s_axi_rvalid = rvalid_ff;
	assign o_s_axi_rdata = rdata_ff;
	assign o_s_axi_rresp = rresp_ff;
	assign o_rc_osc_en = rc_en_ff;
	assign o_clk_sel_internal = sel_ff;
	assign o_wdt_reset = wdt_rst_ff;
	assign o_osc_fail_flag = flag_ff;
	assign o_fail_safe = (state_ff == FAIL_SAFE_MONITOR_ST_FAIL);

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	chk_disabled_quiet: assert property (!en_ff ##1 !en_ff |-> !latch_ff) // RULE1
		else $error("monitor latch active while monitor disabled");
	chk_rc_kept_on: assert property (en_ff |=> o_rc_osc_en) // RULE2
		else $error("RC oscillator dropped while monitor enabled");
	chk_wdt_off_rc: assert property (en_ff && !i_wdt_enable |=> o_rc_osc_en) // RULE10
		else $error("watchdog disable stopped the RC oscillator");
	chk_latch_sets: assert property (monitoring && mon_fall |=> latch_ff) // RULE4
		else $error("monitored clock fall did not set the latch");
	chk_latch_clears: assert property
		(monitoring && samp_rise && !mon_fall |=> !latch_ff) // RULE4
		else $error("sample rise did not clear the latch");
	chk_fail_flag: assert property (fail_det |=> flag_ff && o_osc_fail_flag) // RULE6
		else $error("failure did not set the oscillator fail flag");
	chk_flag_set_wins: assert property (fail_det && irq_clr |=> flag_ff) // RULE6
		else $error("flag clear beat a same-cycle failure");
	chk_failover_sel: assert property
		(fail_det |=> o_clk_sel_internal && o_fail_safe) // RULE5 RULE7
		else $error("failure did not select the internal oscillator");
	chk_osc_reg_kept: assert property
		(fail_det |=> $stable(osc_run_ff)) // RULE7
		else $error("oscillator control changed on fail-over");
	chk_wdt_pulse: assert property
		(fail_det |=> o_wdt_reset ##1 !o_wdt_reset) // RULE8
		else $error("watchdog reset not a single pulse on failure");
	chk_no_int_detect: assert property
		(o_clk_sel_internal |-> !fail_det) // RULE9 RULE16
		else $error("failure detected while on internal oscillator");
	chk_failsafe_hold: assert property
		(o_fail_safe && !pm_pulse |=> o_fail_safe) // RULE11 RULE16
		else $error("fail-safe left without power-managed entry");
	chk_boot_internal: assert property // RULE12 RULE14
		(state_ff == FAIL_SAFE_MONITOR_ST_BOOT |-> o_clk_sel_internal)
		else $error("device not on internal oscillator during start-up");
	chk_primary_switch: assert property
		(state_ff == FAIL_SAFE_MONITOR_ST_BOOT && primary_ready |=>
			!o_clk_sel_internal && osc_run_ff) // RULE13
		else $error("primary ready did not switch and set running bit");
	chk_samp_rise_lvl: assert property (samp_rise |=> samp_clk) // RULE3
		else $error("sample clock low after a sample rise");
	chk_fail_disarm: assert property (o_fail_safe |=> !latch_ff) // RULE16
		else $error("monitor latch still armed in fail-safe");
	chk_pm_leaves: assert property // RULE11
		(o_fail_safe && pm_pulse |=> !o_fail_safe)
		else $error("power-managed entry did not end fail-safe");
	chk_osc_reg_idle: assert property // RULE14
		(state_ff == FAIL_SAFE_MONITOR_ST_BOOT && !primary_ready && !osc_run_ff |=>
			!osc_run_ff)
		else $error("oscillator control left reset state without primary");
	chk_wdt_only_fail: assert property // RULE8
		(!fail_det |=> !o_wdt_reset)
		else $error("watchdog reset pulsed without a failure");

	cov_failover: cover property (fail_det ##1 o_fail_safe);
	cov_pm_exit: cover property (o_fail_safe && pm_pulse ##1 !o_fail_safe);
	cov_boot_run: cover property
		(state_ff == FAIL_SAFE_MONITOR_ST_BOOT ##1 state_ff == FAIL_SAFE_MONITOR_ST_RUN);
	cov_flag_clear: cover property (flag_ff && irq_clr ##1 !flag_ff);
	cov_stopped_watch: cover property (monitoring && samp_fall && !latch_ff);

endmodule
`default_nettype wire

// file: core/fail_safe_monitor_pkg.sv
// Shared constants and types of the fail-safe clock monitor.
package fail_safe_monitor_pkg;

	// Divide ratio from the internal RC oscillator to the sample clock.
	localparam int unsigned FAIL_SAFE_MONITOR_RC_DIV = 64;

	// Register bus geometry.
	localparam int unsigned FAIL_SAFE_MONITOR_AW = 4;
	localparam int unsigned FAIL_SAFE_MONITOR_DW = 32;

	// Register byte offsets.
	localparam logic [FAIL_SAFE_MONITOR_AW-1:0] FAIL_SAFE_MONITOR_OFS_CTRL = 4'h0;
	localparam logic [FAIL_SAFE_MONITOR_AW-1:0] FAIL_SAFE_MONITOR_OFS_OSC = 4'h4;
	localparam logic [FAIL_SAFE_MONITOR_AW-1:0] FAIL_SAFE_MONITOR_OFS_IRQ = 4'h8;
	localparam logic [FAIL_SAFE_MONITOR_AW-1:0] FAIL_SAFE_MONITOR_OFS_STAT = 4'hC;

	// Control register fields.
	localparam int unsigned FAIL_SAFE_MONITOR_CTRL_EN_BIT = 0;
	localparam int unsigned FAIL_SAFE_MONITOR_CTRL_PM_BIT = 1;

	// Oscillator control register fields.
	localparam int unsigned FAIL_SAFE_MONITOR_OSC_RUN_BIT = 3;
	localparam int unsigned FAIL_SAFE_MONITOR_OSC_FSEL_LSB = 4;
	localparam int unsigned FAIL_SAFE_MONITOR_FSEL_W = 3;
	localparam logic [FAIL_SAFE_MONITOR_FSEL_W-1:0] FAIL_SAFE_MONITOR_FSEL_RST = 3'h0;

	// Peripheral interrupt flag register 2 fields.
	localparam int unsigned FAIL_SAFE_MONITOR_IRQ_FAIL_BIT = 7;

	// Status register fields.
	localparam int unsigned FAIL_SAFE_MONITOR_STAT_FAIL_BIT = 0;
	localparam int unsigned FAIL_SAFE_MONITOR_STAT_SEL_BIT = 1;
	localparam int unsigned FAIL_SAFE_MONITOR_STAT_LATCH_BIT = 2;
	localparam int unsigned FAIL_SAFE_MONITOR_STAT_RC_BIT = 3;

	// AXI4-Lite response codes.
	localparam logic [1:0] FAIL_SAFE_MONITOR_RESP_OKAY = 2'h0;
	localparam logic [1:0] FAIL_SAFE_MONITOR_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		FAIL_SAFE_MONITOR_ST_BOOT = 2'b00,
		FAIL_SAFE_MONITOR_ST_RUN = 2'b01,
		FAIL_SAFE_MONITOR_ST_FAIL = 2'b10
	} fail_safe_monitor_state_t;

endpackage

// file: core/fail_safe_monitor_rc_div.sv
// Sample clock divider fed by the internal RC oscillator pin.
`timescale 1ns/1ps
`default_nettype none
module fail_safe_monitor_rc_div #(
	parameter int unsigned P_RC_DIV = fail_safe_monitor_pkg::FAIL_SAFE_MONITOR_RC_DIV
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_rc_osc,
	input wire logic i_run,
	output logic o_samp_clk,
	output logic o_samp_rise,
	output logic o_samp_fall
);
	import fail_safe_monitor_pkg::*;

	localparam int unsigned HALF = P_RC_DIV / 2;
	localparam int unsigned CW = $clog2(HALF);
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);
	localparam logic [CW-1:0] ZERO = '0;

	logic [1:0] rc_sync_ff;
	logic rc_prev_ff;
	logic [CW-1:0] cnt_ff;
	logic samp_ff;

	wire rc_rise = i_run & rc_sync_ff[1] & ~rc_prev_ff;
	wire wrap = rc_rise & (cnt_ff == LAST);
	wire [CW-1:0] nxt_cnt = wrap ? ZERO : (rc_rise ? cnt_ff + 1'b1 : cnt_ff);
	wire nxt_samp = wrap ? ~samp_ff : samp_ff;

	// Each half of the sample clock spans half the RC periods of the ratio.
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rc_sync_ff <= 2'h0;
			rc_prev_ff <= 1'b0;
			cnt_ff <= ZERO;
			samp_ff <= 1'b0;
		end else begin
			rc_sync_ff <= {rc_sync_ff[0], i_rc_osc};
			rc_prev_ff <= rc_sync_ff[1];
			cnt_ff <= nxt_cnt; // RULE3
			samp_ff <= nxt_samp; // RULE3
		end
	end

	assign o_samp_clk = samp_ff;
	assign o_samp_rise = wrap & ~samp_ff;
	assign o_samp_fall = wrap & samp_ff;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	chk_div_toggle: assert property (wrap |=> samp_ff != $past(samp_ff)) // RULE3
		else $error("sample clock did not toggle at divider wrap");
	chk_div_hold: assert property (!wrap |=> $stable(samp_ff)) // RULE3
		else $error("sample clock moved without a divider wrap");

endmodule
`default_nettype wire

// file: testbench/fail_safe_monitor_osc_model.sv
// Behavioural model of the clock sources around the fail-safe monitor.
`timescale 1ns/1ps
`default_nettype none
module fail_safe_monitor_osc_model #(
	parameter realtime P_RC_HALF = 20.0,
	parameter realtime P_MON_HALF = 12.0,
	parameter realtime P_START = 200.0
) (
	input wire logic i_rc_en,
	input wire logic i_mon_run,
	input wire logic i_start_ok,
	output logic o_rc,
	output logic o_mon,
	output logic o_ready
);
	initial begin
		o_rc = 1'b0;
		o_mon = 1'b0;
		o_ready = 1'b0;
	end
	// The RC oscillator only runs while the device asks for it.
	always begin
		#(P_RC_HALF);
		o_rc = i_rc_en ? ~o_rc : 1'b0;
	end
	// A dead crystal stops outright, so the line sits low.
	always begin
		#(P_MON_HALF);
		o_mon = i_mon_run ? ~o_mon : 1'b0;
	end
	// Start-up delay before the primary source reports ready.
	always begin
		wait (i_start_ok === 1'b1);
		#(P_START);
		o_ready = i_start_ok;
		wait (i_start_ok !== 1'b1);
		o_ready = 1'b0;
	end
endmodule
`default_nettype wire

// file: testbench/tb_fail_safe_clock_monitor.sv
// Self-checking testbench of the fail-safe clock monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_fail_safe_clock_monitor;
	import fail_safe_monitor_pkg::*;
	logic sys_clk, reset_n, wdt_en, mon_run, start_ok;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic rc_en, sel_int, wdt_rst, fail_flag, fail_safe, mon_clk, rc_osc, rdy;
	int errors, n_tests, pulses;

	fail_safe_monitor_core #(.P_RC_DIV(4)) uut (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
		.i_mon_clk(mon_clk), .i_int_rc_osc(rc_osc), .i_primary_ready(rdy),
		.i_wdt_enable(wdt_en), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
		.i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_rc_osc_en(rc_en), .o_clk_sel_internal(sel_int),
		.o_wdt_reset(wdt_rst), .o_osc_fail_flag(fail_flag),
		.o_fail_safe(fail_safe));
	fail_safe_monitor_osc_model osc (.i_rc_en(rc_en), .i_mon_run(mon_run),
		.i_start_ok(start_ok), .o_rc(rc_osc), .o_mon(mon_clk), .o_ready(rdy));

	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;
	// Counted mid-cycle, so a check at the next rising edge already sees it.
	always @(negedge sys_clk) begin
		if (wdt_rst === 1'b1) begin
			pulses++;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Bounded wait on fail_safe (fs=1) or the clock select, then a compare.
	task automatic wait_sig(input bit fs, input logic v, input int lim);
		int n;
		n = 0;
		while ((fs ? fail_safe : sel_int) !== v && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		chk(fs ? "fail_safe" : "clk_sel", 32'(v), 32'(fs ? fail_safe : sel_int));
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		bit ad, dd;
		ad = 0;
		dd = 0;
		n = 0;
		@(posedge sys_clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		bready <= 1'b1;
		while (!(ad && dd) && n < 100) begin
			@(posedge sys_clk);
			n++;
			if (awvalid && awready === 1'b1) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				dd = 1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		bready <= 1'b0;
		chk("bvalid", 32'h1, 32'(bvalid));
		chk("bresp", 32'(er), 32'(bresp));
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge sys_clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		// The address stands until a later edge samples arready high.
		@(posedge sys_clk);
		n++;
		while (arready !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		arvalid <= 1'b0;
		while (rvalid !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		rready <= 1'b0;
		chk("rvalid", 32'h1, 32'(rvalid));
		chk("rdata", e, rdata);
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	task automatic t_reset_vals();
		chk("wdt_reset", 32'h0, 32'(wdt_rst));
		wait_sig(0, 1'b1, 0);
		rd(FAIL_SAFE_MONITOR_OFS_OSC, 32'h0, FAIL_SAFE_MONITOR_RESP_OKAY);
		rd(FAIL_SAFE_MONITOR_OFS_CTRL, 32'h0, FAIL_SAFE_MONITOR_RESP_OKAY);
		rd(FAIL_SAFE_MONITOR_OFS_IRQ, 32'h0, FAIL_SAFE_MONITOR_RESP_OKAY);
		rd(FAIL_SAFE_MONITOR_OFS_STAT, 32'h2, FAIL_SAFE_MONITOR_RESP_OKAY);
	endtask
	task automatic t_freq_select();
		wr(FAIL_SAFE_MONITOR_OFS_OSC, 32'hFF, FAIL_SAFE_MONITOR_RESP_OKAY);
		rd(FAIL_SAFE_MONITOR_OFS_OSC, 32'h70, FAIL_SAFE_MONITOR_RESP_OKAY);
		idle(100);
		wait_sig(0, 1'b1, 0);
	endtask
	task automatic t_rc_request();
		wdt_en <= 1'b1;
		idle(3);
		chk("rc_osc_en", 32'h1, 32'(rc_en));
		wdt_en <= 1'b0;
		idle(3);
		chk("rc_osc_en", 32'h0, 32'(rc_en));
		wr(FAIL_SAFE_MONITOR_OFS_CTRL, 32'h1, FAIL_SAFE_MONITOR_RESP_OKAY);
		idle(3);
		chk("rc_osc_en", 32'h1, 32'(rc_en));
	endtask
	// Still booting on the internal source: nothing is watched yet.
	task automatic t_boot_quiet();
		mon_run <= 1'b1;
		idle(400);
		wait_sig(1, 1'b0, 0);
		chk("wdt_pulses", 32'h0, 32'(pulses));
		wr(FAIL_SAFE_MONITOR_OFS_CTRL, 32'h0, FAIL_SAFE_MONITOR_RESP_OKAY);
	endtask
	task automatic t_primary();
		start_ok <= 1'b1;
		wait_sig(0, 1'b0, 200);
		rd(FAIL_SAFE_MONITOR_OFS_OSC, 32'h78, FAIL_SAFE_MONITOR_RESP_OKAY);
		wdt_en <= 1'b1;
		idle(400);
		wait_sig(1, 1'b0, 0);
		wdt_en <= 1'b0;
	endtask
	// A stopped clock leaves the latch clear at every sample fall.
	task automatic t_stopped();
		mon_run <= 1'b0;
		// Let the last fall of the dying clock pass before watching starts.
		idle(10);
		wr(FAIL_SAFE_MONITOR_OFS_CTRL, 32'h1, FAIL_SAFE_MONITOR_RESP_OKAY);
		idle(400);
		wait_sig(1, 1'b0, 0);
	endtask
	task automatic t_failover();
		mon_run <= 1'b1;
		wait_sig(1, 1'b1, 600);
		chk("clk_sel", 32'h1, 32'(sel_int));
		chk("osc_fail_flag", 32'h1, 32'(fail_flag));
		chk("wdt_pulses", 32'h1, 32'(pulses));
		rd(FAIL_SAFE_MONITOR_OFS_OSC, 32'h78, FAIL_SAFE_MONITOR_RESP_OKAY);
		rd(FAIL_SAFE_MONITOR_OFS_IRQ, 32'h80, FAIL_SAFE_MONITOR_RESP_OKAY);
		rd(FAIL_SAFE_MONITOR_OFS_STAT, 32'hB, FAIL_SAFE_MONITOR_RESP_OKAY);
		idle(400);
		chk("wdt_pulses", 32'h1, 32'(pulses));
		wr(FAIL_SAFE_MONITOR_OFS_IRQ, 32'h80, FAIL_SAFE_MONITOR_RESP_OKAY);
		rd(FAIL_SAFE_MONITOR_OFS_IRQ, 32'h0, FAIL_SAFE_MONITOR_RESP_OKAY);
	endtask
	task automatic t_pm_exit();
		wr(FAIL_SAFE_MONITOR_OFS_CTRL, 32'h3, FAIL_SAFE_MONITOR_RESP_OKAY);
		wait_sig(0, 1'b0, 50);
		wait_sig(1, 1'b1, 600);
		chk("wdt_pulses", 32'h2, 32'(pulses));
		reset_n <= 1'b0;
		idle(8);
		wait_sig(1, 1'b0, 0);
		wait_sig(0, 1'b1, 0);
		chk("osc_fail_flag", 32'h0, 32'(fail_flag));
		reset_n <= 1'b1;
		mon_run <= 1'b0;
		rd(FAIL_SAFE_MONITOR_OFS_CTRL, 32'h0, FAIL_SAFE_MONITOR_RESP_OKAY);
	endtask
	task automatic t_unmapped();
		wr(4'h2, 32'h1, FAIL_SAFE_MONITOR_RESP_SLVERR);
		rd(4'h2, 32'h0, FAIL_SAFE_MONITOR_RESP_SLVERR);
	endtask

	task automatic summarize();
		if (errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// The whole run needs about two thousand cycles.
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		summarize();
	end
	initial begin
		reset_n = 1'b0;
		wdt_en = 1'b0;
		mon_run = 1'b0;
		start_ok = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wstrb = 4'h0;
		wdata = 32'h0;
		errors = 0;
		n_tests = 0;
		pulses = 0;
		idle(8);
		reset_n <= 1'b1;
		t_reset_vals();
		t_freq_select();
		t_rc_request();
		t_boot_quiet();
		t_primary();
		t_stopped();
		t_failover();
		t_pm_exit();
		t_unmapped();
		summarize();
	end
endmodule
`default_nettype wire
